// file: pkg/pppc_pkg.sv
// shared constants and types of the parallel port pin control block
package pppc_pkg;
    // line counts: four bidirectional ports and two input-only ports
    localparam int N_BIDIR = 30;
    localparam int N_INONLY = 9;
    localparam int N_LINES = N_BIDIR + N_INONLY;
    // positions of each port inside the flat bidirectional vector
    localparam int PORT_A_LSB = 0;
    localparam int PORT_A_W = 11;
    localparam int PORT_B_LSB = 11;
    localparam int PORT_B_W = 2;
    localparam int PORT_C_LSB = 13;
    localparam int PORT_C_W = 1;
    localparam int WIDE_BIDIR_PORT_LSB = 14;
    localparam int WIDE_BIDIR_PORT_W = 16;
    // positions of each port inside the flat input-only vector
    localparam int ANALOG_SHARED_INPUT_PORT_LSB = 0;
    localparam int ANALOG_SHARED_INPUT_PORT_W = 7;
    localparam int AUX_INPUT_PORT_LSB = 7;
    localparam int AUX_INPUT_PORT_W = 2;
    // peripheral input routing channels
    localparam int N_ROUTE = 4;
    localparam int ROUTE_W = 6;
    // register byte offsets
    localparam int ADDR_W = 12;
    localparam logic [11:0] LCTRL_BASE = 12'h000;
    localparam logic [11:0] OUT_OFS = 12'h100;
    localparam logic [11:0] OUT_SET_OFS = 12'h104;
    localparam logic [11:0] OUT_CLR_OFS = 12'h108;
    localparam logic [11:0] IN_BIDIR_OFS = 12'h10c;
    localparam logic [11:0] IN_ONLY_OFS = 12'h110;
    localparam logic [11:0] DIDIS_OFS = 12'h114;
    localparam logic [11:0] ROUTE_BASE = 12'h120;
    // line control field positions
    localparam int F_DIR = 0;
    localparam int F_OD = 1;
    localparam int F_PULL_EN = 2;
    localparam int F_PULL_UP = 3;
    localparam int F_SLOW = 4;
    localparam int F_STR_LSB = 5;
    localparam int F_SEL_LSB = 7;
    localparam int LCTRL_W = 9;
    // values after reset
    localparam logic [8:0] LCTRL_RST = 9'h000;
    localparam logic [1:0] STRENGTH_RST = 2'h0;
    localparam logic [31:0] OUT_RST = 32'h0000_0000;
    localparam logic [31:0] DIDIS_RST = 32'h0000_0000;
    localparam logic [5:0] ROUTE_RST = 6'h00;
    // output source of a bidirectional line
    typedef enum logic [1:0] {
        PPPC_SEL_GPIO,
        PPPC_SEL_ALT1,
        PPPC_SEL_ALT2,
        PPPC_SEL_ALT3
    } pppc_sel_e;
endpackage : pppc_pkg

// file: pkg/pppc_pad_if.sv
// per-line driver settings passed from the register file to the pad driver stage
interface pppc_pad_if import pppc_pkg::*; #(
    parameter int N = N_BIDIR
);
    logic [N-1:0] dir;
    logic [N-1:0] od;
    logic [N-1:0] pull_en;
    logic [N-1:0] pull_up;
    logic [N-1:0] slow;
    logic [N-1:0] gpio;
    logic [N-1:0] alt1;
    logic [N-1:0] alt2;
    logic [N-1:0] alt3;
    logic [N-1:0][1:0] strength;
    pppc_sel_e [N-1:0] sel;
    modport ctl (output dir, od, pull_en, pull_up, slow, gpio, alt1, alt2, alt3, strength, sel);
    modport pad (input dir, od, pull_en, pull_up, slow, gpio, alt1, alt2, alt3, strength, sel);
endinterface : pppc_pad_if

// file: hw/pppc_sync.sv
// two-stage synchroniser for pin input levels
module pppc_sync import pppc_pkg::*; #(
    parameter int W = N_LINES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule : pppc_sync

// file: hw/pppc_pad.sv
// pad driver stage: selects each line's output source and registers driver controls
module pppc_pad import pppc_pkg::*; #(
    parameter int N = N_BIDIR
) (
    input wire logic clk,
    input wire logic rst_n,
    pppc_pad_if.pad cfg,
    output logic [N-1:0] pin_o,
    output logic [N-1:0] pin_oe,
    output logic [N-1:0] pull_en,
    output logic [N-1:0] pull_up,
    output logic [N-1:0] slow,
    output logic [N-1:0][1:0] strength
);
    logic [N-1:0] src;
    logic [N-1:0] nxt_o;
    logic [N-1:0] nxt_oe;
    logic [N-1:0] o_ff;
    logic [N-1:0] oe_ff;
    logic [N-1:0] pull_en_ff;
    logic [N-1:0] pull_up_ff;
    logic [N-1:0] slow_ff;
    logic [N-1:0][1:0] strength_ff;

    always_comb begin
        for (int l = 0; l < N; l++) begin
            unique case (cfg.sel[l])
                PPPC_SEL_GPIO: src[l] = cfg.gpio[l];
                PPPC_SEL_ALT1: src[l] = cfg.alt1[l];
                PPPC_SEL_ALT2: src[l] = cfg.alt2[l];
                PPPC_SEL_ALT3: src[l] = cfg.alt3[l];
            endcase
        end
    end

    // input lines float; open-drain lines only pull low
    assign nxt_oe = cfg.dir & (~cfg.od | ~src);
    assign nxt_o = ~cfg.od & src;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            o_ff <= '0;
            oe_ff <= '0;
            pull_en_ff <= '0;
            pull_up_ff <= '0;
            slow_ff <= '0;
            strength_ff <= {N{STRENGTH_RST}};
        end else begin
            o_ff <= nxt_o;
            oe_ff <= nxt_oe;
            pull_en_ff <= cfg.pull_en;
            pull_up_ff <= cfg.pull_up;
            slow_ff <= cfg.slow;
            strength_ff <= cfg.strength;
        end
    end

    assign pin_o = o_ff;
    assign pin_oe = oe_ff;
    assign pull_en = pull_en_ff;
    assign pull_up = pull_up_ff;
    assign slow = slow_ff;
    assign strength = strength_ff;
endmodule : pppc_pad

// file: hw/pppc_top.sv
// parallel port pin control: apb register file, pad drivers and input synchronisers
// Notes on behaviour
// - each bidirectional line has its own direction bit, written independently of others.
// - each line chooses push-pull or open-drain drive and switches its pull device.
// - each line chooses its output edge shape and driver current strength.
// - a line set as input has its output driver in high impedance.
// - under reset every pin is an input with all pull devices off.
// - software reads and modifies single port bits without touching the other lines.
// - every bidirectional line offers alternate functions, and peripheral inputs are routed by programming.
// - a line with no alternate function stays a general purpose line under software.
// - 39 lines, as four bidirectional ports and two input-only ports.
// - the analog-shared input-only port has 7 lines, no drivers, and feeds peripherals.
// - the widest bidirectional port has 16 lines carrying alternate functions.
// - each analog pin's digital input stage can be disabled on its own.
// - analog pins not used for conversion still read as digital inputs.
module pppc_top import pppc_pkg::*; #(
    parameter int NB = N_BIDIR,
    parameter int NI = N_INONLY
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NB-1:0] bidir_pin_i,
    output logic [NB-1:0] bidir_pin_o,
    output logic [NB-1:0] bidir_pin_oe,
    output logic [NB-1:0] pad_pull_en,
    output logic [NB-1:0] pad_pull_up,
    output logic [NB-1:0] pad_slow_edge,
    output logic [NB-1:0][1:0] pad_strength,
    input wire logic [NI-1:0] input_pin_i,
    output logic [NI-1:0] input_dig_en,
    input wire logic [NB-1:0] alt1_out,
    input wire logic [NB-1:0] alt2_out,
    input wire logic [NB-1:0] alt3_out,
    output logic [NB+NI-1:0] line_level,
    output logic [N_ROUTE-1:0] routed_in
);
    function automatic logic at(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction : at

    function automatic logic pick(input logic [NB+NI-1:0] lv, input logic [ROUTE_W-1:0] s);
        return (int'(s) < NB + NI) ? lv[s] : 1'b0;
    endfunction : pick

    logic [NB-1:0][LCTRL_W-1:0] lctrl_ff;
    logic [NB-1:0] out_ff;
    logic [NB-1:0] nxt_out;
    logic [NI-1:0] didis_ff;
    logic [NI-1:0] dig_en_ff;
    logic [N_ROUTE-1:0][ROUTE_W-1:0] route_ff;
    logic [N_ROUTE-1:0] routed_ff;
    logic [N_ROUTE-1:0] nxt_routed;
    logic [31:0] prdata_ff;
    logic err_ff;
    logic [NB+NI-1:0] lvl;

    pppc_pad_if #(.N(NB)) pad_if ();

    // apb phase decode
    wire logic setup_ph = psel & ~penable;
    wire logic access_ph = psel & penable;
    wire logic acc_wr = access_ph & pwrite;
    wire logic [5:0] word_idx = paddr[7:2];
    wire logic [1:0] route_idx = paddr[3:2];
    wire logic hit_lctrl = (paddr[11:8] == LCTRL_BASE[11:8]) && (paddr[1:0] == 2'h0)
        && (int'(word_idx) < NB);
    wire logic hit_out = at(paddr, OUT_OFS);
    wire logic hit_set = at(paddr, OUT_SET_OFS);
    wire logic hit_clr = at(paddr, OUT_CLR_OFS);
    wire logic hit_inb = at(paddr, IN_BIDIR_OFS);
    wire logic hit_ini = at(paddr, IN_ONLY_OFS);
    wire logic hit_didis = at(paddr, DIDIS_OFS);
    wire logic hit_route = (paddr[11:4] == ROUTE_BASE[11:4]) && (paddr[1:0] == 2'h0);
    wire logic mapped = hit_lctrl | hit_out | hit_set | hit_clr | hit_inb | hit_ini
        | hit_didis | hit_route;

    // write strobes take effect at the access edge
    wire logic wr_lctrl = acc_wr & hit_lctrl;
    wire logic wr_out = acc_wr & hit_out;
    wire logic wr_set = acc_wr & hit_set;
    wire logic wr_clr = acc_wr & hit_clr;
    wire logic wr_didis = acc_wr & hit_didis;
    wire logic wr_route = acc_wr & hit_route;
    wire logic [NB-1:0] wdata_nb = pwdata[NB-1:0];
    wire logic wdata_dir = pwdata[F_DIR];

    // bit-wise output update: whole word, set-only or clear-only
    assign nxt_out = wr_out ? wdata_nb
        : wr_set ? (out_ff | wdata_nb)
        : wr_clr ? (out_ff & ~wdata_nb)
        : out_ff;

    // read selection, captured in the setup cycle
    wire logic [31:0] rd_mux = hit_lctrl ? 32'(lctrl_ff[word_idx])
        : hit_out ? 32'(out_ff)
        : hit_inb ? 32'(lvl[NB-1:0])
        : hit_ini ? 32'(lvl[NB+:NI])
        : hit_didis ? 32'(didis_ff)
        : hit_route ? 32'(route_ff[route_idx])
        : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lctrl_ff <= {NB{LCTRL_RST}};
            out_ff <= OUT_RST[NB-1:0];
        end else begin
            if (wr_lctrl) begin
                lctrl_ff[word_idx] <= pwdata[LCTRL_W-1:0];
            end
            out_ff <= nxt_out;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            didis_ff <= DIDIS_RST[NI-1:0];
            dig_en_ff <= '1;
            route_ff <= {N_ROUTE{ROUTE_RST}};
            routed_ff <= '0;
        end else begin
            if (wr_didis) begin
                didis_ff <= pwdata[NI-1:0];
            end
            dig_en_ff <= ~didis_ff;
            if (wr_route) begin
                route_ff[route_idx] <= pwdata[ROUTE_W-1:0];
            end
            routed_ff <= nxt_routed;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
            err_ff <= 1'b0;
        end else if (setup_ph) begin
            prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
            err_ff <= ~mapped;
        end
    end

    // each routed peripheral input picks one synchronised line
    always_comb begin
        for (int k = 0; k < N_ROUTE; k++) begin
            nxt_routed[k] = pick(lvl, route_ff[k]);
        end
    end

    // line control fields towards the pad driver stage
    always_comb begin
        for (int l = 0; l < NB; l++) begin
            pad_if.dir[l] = lctrl_ff[l][F_DIR];
            pad_if.od[l] = lctrl_ff[l][F_OD];
            pad_if.pull_en[l] = lctrl_ff[l][F_PULL_EN];
            pad_if.pull_up[l] = lctrl_ff[l][F_PULL_UP];
            pad_if.slow[l] = lctrl_ff[l][F_SLOW];
            pad_if.strength[l] = lctrl_ff[l][F_STR_LSB+:2];
            pad_if.sel[l] = pppc_sel_e'(lctrl_ff[l][F_SEL_LSB+:2]);
        end
    end

    assign pad_if.gpio = out_ff;
    assign pad_if.alt1 = alt1_out;
    assign pad_if.alt2 = alt2_out;
    assign pad_if.alt3 = alt3_out;

    pppc_pad #(.N(NB)) u_pad (
        .clk(pclk),
        .rst_n(presetn),
        .cfg(pad_if.pad),
        .pin_o(bidir_pin_o),
        .pin_oe(bidir_pin_oe),
        .pull_en(pad_pull_en),
        .pull_up(pad_pull_up),
        .slow(pad_slow_edge),
        .strength(pad_strength)
    );

    // disabled digital stages read as low; input-only lines have no driver
    wire logic [NI-1:0] in_gated = input_pin_i & ~didis_ff;

    pppc_sync #(.W(NB+NI)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({in_gated, bidir_pin_i}),
        .q(lvl)
    );

    assign line_level = lvl;
    assign routed_in = routed_ff;
    assign input_dig_en = dig_en_ff;
    assign prdata = prdata_ff;
    assign pready = access_ph;
    assign pslverr = access_ph & err_ff;

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [NB-1:0] dir_vec;
    logic [NB-1:0] od_vec;
    logic [NB-1:0] gpio_vec;
    logic [NB-1:0] alt1_vec;
    always_comb begin
        for (int l = 0; l < NB; l++) begin
            dir_vec[l] = lctrl_ff[l][F_DIR];
            od_vec[l] = lctrl_ff[l][F_OD];
            gpio_vec[l] = lctrl_ff[l][F_SEL_LSB+:2] == 2'h0;
            alt1_vec[l] = lctrl_ff[l][F_SEL_LSB+:2] == 2'h1;
        end
    end

    input_hiz_a: assert property ((bidir_pin_oe & ~$past(dir_vec)) == '0)
        else $error("driver enabled on an input line");

    od_no_high_a: assert property ((bidir_pin_oe & bidir_pin_o & $past(od_vec)) == '0)
        else $error("open-drain line driven high");

    reset_input_a: assert property ($rose(presetn) |->
            (bidir_pin_oe == '0 && pad_pull_en == '0) ##1
            (bidir_pin_oe == '0 && pad_pull_en == '0))
        else $error("pins not inputs without pulls after reset");

    dir_write_a: assert property (wr_lctrl |=>
            lctrl_ff[$past(word_idx)][F_DIR] == $past(wdata_dir))
        else $error("direction bit not written");

    bit_set_a: assert property (wr_set |=> out_ff == ($past(out_ff) | $past(wdata_nb)))
        else $error("set write disturbed other bits");

    bit_clr_a: assert property (wr_clr |=> out_ff == ($past(out_ff) & ~$past(wdata_nb)))
        else $error("clear write disturbed other bits");

    gpio_drive_a: assert property (
            ((bidir_pin_o ^ $past(out_ff)) & $past(dir_vec & ~od_vec & gpio_vec)) == '0)
        else $error("general purpose line does not drive its output bit");

    strength_a: assert property (pad_strength == $past(pad_if.strength))
        else $error("driver strength does not follow line control");

    sync_delay_a: assert property ($past(presetn, 2) |->
            lvl[NB-1:0] == $past(bidir_pin_i, 2))
        else $error("pin level not delayed by two stages");

    didis_low_a: assert property ((lvl[NB+:NI] & $past(didis_ff, 2)) == '0)
        else $error("disabled digital input stage passed a level");

    route_a: assert property (routed_in[0] == $past(pick(lvl, route_ff[0])))
        else $error("routed input does not follow its selected line");

    unmapped_err_a: assert property (setup_ph && !mapped |=> pready && pslverr)
        else $error("unmapped access not answered with an error");

    dig_en_a: assert property (input_dig_en == ~$past(didis_ff))
        else $error("digital input enable does not follow disable bits");

    pull_follow_a: assert property (pad_pull_en == $past(pad_if.pull_en)
            && pad_pull_up == $past(pad_if.pull_up))
        else $error("pull controls do not follow line control");

    slow_follow_a: assert property (pad_slow_edge == $past(pad_if.slow))
        else $error("edge shape does not follow line control");

    out_write_a: assert property (wr_out |=> out_ff == $past(wdata_nb))
        else $error("output word not written");

    ctrl_keep_a: assert property (!wr_lctrl |=> lctrl_ff == $past(lctrl_ff))
        else $error("line control changed without a write");

    out_read_a: assert property (access_ph && !pwrite && hit_out |->
            prdata == 32'($past(out_ff)))
        else $error("output word read back wrong");

    in_read_a: assert property (access_ph && !pwrite && hit_ini |->
            prdata == 32'($past(lvl[NB+:NI])))
        else $error("input-only levels read back wrong");

    alt_select_a: assert property (
            ((bidir_pin_o ^ $past(alt1_out)) & $past(dir_vec & ~od_vec & alt1_vec)) == '0)
        else $error("line does not drive its first alternate output");

    od_low_a: assert property (
            ($past(dir_vec & od_vec & gpio_vec & ~out_ff) & ~bidir_pin_oe) == '0)
        else $error("open-drain line not pulled low");

    oe_dir_a: assert property (
            ((bidir_pin_oe ^ $past(dir_vec)) & ~$past(od_vec)) == '0)
        else $error("push-pull driver enable does not follow direction");

    od_line_c: cover property (wr_lctrl && pwdata[F_DIR] && pwdata[F_OD]);
    bit_mod_c: cover property (wr_set ##[1:4] wr_clr);
    didis_c: cover property (wr_didis && pwdata[NI-1:0] != '0);
    alt_drive_c: cover property ((bidir_pin_oe & ~$past(gpio_vec)) != '0);
    route_inonly_c: cover property (wr_route && int'(pwdata[ROUTE_W-1:0]) >= NB);
endmodule : pppc_top

// file: dv/pppc_board.sv
// board circuitry model: resolves each bidirectional pin level
module pppc_board import pppc_pkg::*; #(
    parameter int N = N_BIDIR
) (
    input wire logic clk,
    input wire logic [N-1:0] pin_o,
    input wire logic [N-1:0] pin_oe,
    input wire logic [N-1:0] pull_en,
    input wire logic [N-1:0] pull_up,
    input wire logic [N-1:0] ext_en,
    input wire logic [N-1:0] ext_val,
    output logic [N-1:0] pin_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip_ff = 1'b0;
    // a floating line with no pull shows a level that changes every cycle
    always_ff @(posedge clk) begin
        flip_ff <= ~flip_ff;
    end
    always_comb begin
        for (int l = 0; l < N; l++) begin
            if (pin_oe[l]) begin
                pin_i[l] = pin_o[l];
            end else if (ext_en[l]) begin
                pin_i[l] = ext_val[l];
            end else if (pull_en[l]) begin
                pin_i[l] = pull_up[l];
            end else begin
                pin_i[l] = flip_ff ^ l[0];
            end
        end
    end
endmodule : pppc_board

// file: dv/tb.sv
// self-checking bench for the parallel port pin control block
module tb import pppc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NB = N_BIDIR;
    localparam int NI = N_INONLY;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NB-1:0] pin_i;
    logic [NB-1:0] pin_o;
    logic [NB-1:0] pin_oe;
    logic [NB-1:0] pull_en;
    logic [NB-1:0] pull_up;
    logic [NB-1:0] slow;
    logic [NB-1:0][1:0] strength;
    logic [NI-1:0] in_pin = '0;
    logic [NI-1:0] dig_en;
    logic [NB-1:0] alt1 = '0;
    logic [NB-1:0] alt2 = '0;
    logic [NB-1:0] alt3 = '0;
    logic [NB+NI-1:0] level;
    logic [N_ROUTE-1:0] routed;
    logic [NB-1:0] ext_en = '0;
    logic [NB-1:0] ext_val = '0;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int checked = 0;

    always #10 pclk = ~pclk;

    pppc_top #(.NB(NB), .NI(NI)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bidir_pin_i(pin_i), .bidir_pin_o(pin_o), .bidir_pin_oe(pin_oe),
        .pad_pull_en(pull_en), .pad_pull_up(pull_up), .pad_slow_edge(slow),
        .pad_strength(strength), .input_pin_i(in_pin), .input_dig_en(dig_en),
        .alt1_out(alt1), .alt2_out(alt2), .alt3_out(alt3), .line_level(level),
        .routed_in(routed)
    );

    pppc_board #(.N(NB)) u_board (
        .clk(pclk), .pin_o(pin_o), .pin_oe(pin_oe), .pull_en(pull_en), .pull_up(pull_up),
        .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i)
    );

    function automatic logic [11:0] lc(input int l);
        return LCTRL_BASE + 12'(4 * l);
    endfunction : lc

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            n_errors++;
            $display("bus transfer got no answer");
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, rd, err);
        chk(rd, exp);
        chk(32'(err), 32'h0000_0000);
    endtask : rdc

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : settle

    task automatic t_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        settle(16);
        chk(32'(pin_oe), 32'h0000_0000);
        chk(32'(pull_en), 32'h0000_0000);
        chk(32'(dig_en), 32'h0000_01ff);
        @(posedge pclk);
        presetn <= 1'b1;
        rdc(lc(5), 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_dir();
        wr(OUT_OFS, 32'h0000_0008);
        wr(lc(3), 32'h1 << F_DIR);
        settle(2);
        chk(32'(pin_oe), 32'h0000_0008);
        chk(32'(pin_o[3]), 32'h0000_0001);
        apb(1'b0, IN_BIDIR_OFS, 32'h0000_0000, rd, err);
        chk(rd & 32'h0000_0008, 32'h0000_0008);
        wr(OUT_CLR_OFS, 32'h0000_0008);
        settle(2);
        chk(32'(pin_o[3]), 32'h0000_0000);
        wr(lc(3), 32'h0000_0000);
        settle(2);
        chk(32'(pin_oe), 32'h0000_0000);
        $display("test direction done");
    endtask : t_dir

    task automatic t_pad();
        wr(lc(5), 32'h0000_007f);
        settle(2);
        chk(32'(pin_oe[5]), 32'h0000_0001);
        chk(32'(pin_o[5]), 32'h0000_0000);
        chk(32'({pull_en[5], pull_up[5], slow[5], strength[5]}), 32'h0000_001f);
        rdc(lc(5), 32'h0000_007f);
        wr(OUT_SET_OFS, 32'h0000_0020);
        settle(4);
        chk(32'(pin_oe[5]), 32'h0000_0000);
        chk(32'(level[5]), 32'h0000_0001);
        $display("test pad controls done");
    endtask : t_pad

    task automatic t_setclr();
        wr(OUT_SET_OFS, 32'h0000_0011);
        wr(OUT_CLR_OFS, 32'h0000_0020);
        rdc(OUT_OFS, 32'h0000_0011);
        rdc(OUT_SET_OFS, 32'h0000_0000);
        $display("test set clear done");
    endtask : t_setclr

    task automatic t_alt();
        logic [NB-1:0] m;
        m = '0;
        m[20] = 1'b1;
        for (int s = 1; s <= 3; s++) begin
            wr(lc(20), (32'(s) << F_SEL_LSB) | 32'h1);
            @(posedge pclk);
            alt1 <= (s == 1) ? m : ~m;
            alt2 <= (s == 2) ? m : ~m;
            alt3 <= (s == 3) ? m : ~m;
            settle(2);
            chk(32'(pin_o[20]), 32'h0000_0001);
            @(posedge pclk);
            alt1 <= ~alt1;
            alt2 <= ~alt2;
            alt3 <= ~alt3;
            settle(2);
            chk(32'(pin_o[20]), 32'h0000_0000);
        end
        $display("test alternate done");
    endtask : t_alt

    task automatic t_input();
        @(posedge pclk);
        ext_en[14] <= 1'b1;
        ext_val[14] <= 1'b1;
        in_pin <= 9'h1ff;
        wr(ROUTE_BASE + 12'h004, 32'd32);
        settle(3);
        chk(32'(level[14]), 32'h0000_0001);
        chk(32'(level[38:30]), 32'h0000_01ff);
        chk(32'(routed[1]), 32'h0000_0001);
        @(posedge pclk);
        ext_val[14] <= 1'b0;
        settle(1);
        chk(32'(level[14]), 32'h0000_0001);
        settle(1);
        chk(32'(level[14]), 32'h0000_0000);
        wr(DIDIS_OFS, 32'h0000_0004);
        settle(4);
        chk(32'(dig_en), 32'h0000_01fb);
        chk(32'(level[38:30]), 32'h0000_01fb);
        chk(32'(routed[1]), 32'h0000_0000);
        rdc(IN_ONLY_OFS, 32'h0000_01fb);
        $display("test inputs done");
    endtask : t_input

    task automatic t_refuse();
        apb(1'b0, lc(30), 32'h0000_0000, rd, err);
        chk(rd, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        apb(1'b0, 12'h102, 32'h0000_0000, rd, err);
        chk(32'(err), 32'h0000_0001);
        apb(1'b1, IN_BIDIR_OFS, 32'hffff_ffff, rd, err);
        chk(32'(err), 32'h0000_0000);
        rdc(lc(29), 32'h0000_0000);
        $display("test refusals done");
    endtask : t_refuse

    initial begin
        t_reset();
        t_dir();
        t_pad();
        t_setclr();
        t_alt();
        t_input();
        t_refuse();
        t_reset();
        conclude();
    end

    initial begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        $display("watchdog expired");
        conclude();
    end
endmodule : tb
